// [rtl/stss_core.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// torque command conditioning, speed status and main power sequence
// Functional notes
// - polarity 0: positive command gives ccw torque; 1 gives cw torque
// - torque clamped both ways to first limit or system maximum if lower, 0 to 500 percent
// - limit source select and second limit have no effect here
// - first limit writes above system maximum torque are refused
// - zero speed out when speed magnitude below zero speed threshold
// - speed match out when magnitude of command minus speed below that threshold
// - zero speed compare uses magnitude, same for both directions
// - zero speed compare has a 10 rpm hysteresis
// - at speed out when speed magnitude above at speed threshold
// - at speed compare is sign free with 10 rpm hysteresis
// - power loss counts only after shutoff lasts the detect time
// - trip select 0: loss during servo on drops servo, resumes later
// - trip select 1, default: loss during servo on trips undervoltage
// - trip select ignored when detect time equals 1000
// - low converter bus voltage during servo on always trips, even before detection
module stss_core
  import stss_pkg::*;
#(
  parameter int CYC_PER_MS = STSS_CYC_PER_MS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // parameter access
  input wire logic param_wr_en,
  input wire logic param_rd_en,
  input wire logic [STSS_ADDR_W-1:0] param_addr,
  input wire logic [STSS_DATA_W-1:0] param_wr_data,
  output logic [STSS_DATA_W-1:0] param_rd_data,
  output logic param_wr_reject,
  // fixed system settings
  input wire logic [15:0] sys_max_torque,
  input wire logic [15:0] power_off_detect_time,
  // commands and feedback
  input wire logic signed [15:0] analog_cmd_input_a,
  input wire logic signed [15:0] speed_cmd,
  input wire logic signed [15:0] motor_speed,
  input wire logic servo_on_req,
  input wire logic alarm_clear,
  input wire logic main_power_ok,
  input wire logic bus_volt_low,
  // status and drive outputs
  output logic signed [STSS_TQ_W-1:0] torque_out,
  output logic zero_speed_out,
  output logic alt_limit_status_out,
  output logic speed_match_out,
  output logic at_speed_out,
  output logic servo_active,
  output logic undervoltage_error
);

  // ========================================================================
  // helpers
  function automatic logic [STSS_MAG_W-1:0] f_abs(
    input logic signed [STSS_MAG_W:0] v
  );
    logic signed [STSS_MAG_W:0] n;
    n = -v;
    f_abs = v[STSS_MAG_W] ? n[STSS_MAG_W-1:0] : v[STSS_MAG_W-1:0];
  endfunction

  function automatic logic [15:0] f_min(
    input logic [15:0] a,
    input logic [15:0] b
  );
    f_min = (a < b) ? a : b;
  endfunction

  // ========================================================================
  // parameter registers
  logic [15:0] polarity_r;
  logic [15:0] first_limit_r;
  logic [15:0] zs_thr_r;
  logic [15:0] at_thr_r;
  logic [15:0] trip_sel_r;
  logic [15:0] rd_data_r;
  logic wr_reject_r;
  logic wr_bad;

  // out-of-range writes leave the old value in place
  always_comb begin
    case (param_addr)
      STSS_OFS_POLARITY: wr_bad = param_wr_data > STSS_FLAG_MAX;
      STSS_OFS_FIRST_LIMIT: wr_bad = (param_wr_data > STSS_LIMIT_MAX) ||
        (param_wr_data > sys_max_torque);
      STSS_OFS_ZS_THR,
      STSS_OFS_AT_THR: wr_bad = (param_wr_data < STSS_THR_MIN) ||
        (param_wr_data > STSS_THR_MAX);
      STSS_OFS_TRIP_SEL: wr_bad = param_wr_data > STSS_FLAG_MAX;
      default: wr_bad = 1'b1;
    endcase
  end

  // parameter storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      polarity_r <= STSS_RST_POLARITY;
      first_limit_r <= STSS_RST_FIRST_LIMIT;
      zs_thr_r <= STSS_RST_THR;
      at_thr_r <= STSS_RST_THR;
      trip_sel_r <= STSS_RST_TRIP_SEL;
    end else if (param_wr_en && !wr_bad) begin
      case (param_addr)
        STSS_OFS_POLARITY: polarity_r <= param_wr_data;
        STSS_OFS_FIRST_LIMIT: first_limit_r <= param_wr_data;
        STSS_OFS_ZS_THR: zs_thr_r <= param_wr_data;
        STSS_OFS_AT_THR: at_thr_r <= param_wr_data;
        STSS_OFS_TRIP_SEL: trip_sel_r <= param_wr_data;
        default: ;
      endcase
    end
  end

  // reject pulse and registered read data, unmapped reads give zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_reject_r <= 1'b0;
      rd_data_r <= '0;
    end else begin
      wr_reject_r <= param_wr_en && wr_bad;
      if (param_rd_en) begin
        case (param_addr)
          STSS_OFS_POLARITY: rd_data_r <= polarity_r;
          STSS_OFS_FIRST_LIMIT: rd_data_r <= first_limit_r;
          STSS_OFS_ZS_THR: rd_data_r <= zs_thr_r;
          STSS_OFS_AT_THR: rd_data_r <= at_thr_r;
          STSS_OFS_TRIP_SEL: rd_data_r <= trip_sel_r;
          default: rd_data_r <= '0;
        endcase
      end
    end
  end

  assign param_rd_data = rd_data_r;
  assign param_wr_reject = wr_reject_r;

  // ========================================================================
  // torque conditioning
  logic [15:0] lim_eff;
  logic signed [STSS_TQ_W:0] cmd_pol;
  logic signed [STSS_TQ_W:0] lim_s;
  logic signed [STSS_TQ_W-1:0] torque_nxt;
  logic signed [STSS_TQ_W-1:0] torque_r;
  logic signed [STSS_TQ_W:0] lim_neg;
  logic servo_active_r;

  // the first limit, capped at the system maximum, governs; no other limit source is looked at
  always_comb begin
    lim_eff = f_min(first_limit_r, sys_max_torque);
    lim_s = $signed({2'b00, lim_eff});
    lim_neg = -lim_s;
    cmd_pol = polarity_r[0] ? -(STSS_TQ_W+1)'(analog_cmd_input_a)
                            : (STSS_TQ_W+1)'(analog_cmd_input_a);
    if (cmd_pol > lim_s) begin
      torque_nxt = lim_s[STSS_TQ_W-1:0];
    end else if (cmd_pol < -lim_s) begin
      torque_nxt = lim_neg[STSS_TQ_W-1:0];
    end else begin
      torque_nxt = cmd_pol[STSS_TQ_W-1:0];
    end
  end

  // positive output means ccw torque; zero while servo is off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      torque_r <= '0;
    end else begin
      torque_r <= servo_active_r ? torque_nxt : '0;
    end
  end

  assign torque_out = torque_r;

  // ========================================================================
  // speed status
  logic [STSS_MAG_W-1:0] spd_mag;
  logic [STSS_MAG_W-1:0] diff_mag;
  logic zs_flag;
  logic match_flag;
  logic at_flag;
  logic [STSS_MAG_W-1:0] zs_thr_x;
  logic [STSS_MAG_W-1:0] at_thr_x;

  // magnitudes, so both directions compare alike
  always_comb begin
    spd_mag = f_abs((STSS_MAG_W+1)'(motor_speed));
    diff_mag = f_abs((STSS_MAG_W+1)'(speed_cmd) -
                     (STSS_MAG_W+1)'(motor_speed));
    zs_thr_x = STSS_MAG_W'(zs_thr_r);
    at_thr_x = STSS_MAG_W'(at_thr_r);
  end

  stss_hyst_cmp #(
    .W(STSS_MAG_W),
    .HYST(STSS_MAG_W'(STSS_HYST_RPM)),
    .BELOW(1'b1)
  ) u_zero_speed (
    .clock(clock),
    .reset_n(reset_n),
    .mag(spd_mag),
    .thr(zs_thr_x),
    .flag_r(zs_flag)
  );

  // no band on the match flag, it follows the difference directly
  stss_hyst_cmp #(
    .W(STSS_MAG_W),
    .HYST('0),
    .BELOW(1'b1)
  ) u_speed_match (
    .clock(clock),
    .reset_n(reset_n),
    .mag(diff_mag),
    .thr(zs_thr_x),
    .flag_r(match_flag)
  );

  stss_hyst_cmp #(
    .W(STSS_MAG_W),
    .HYST(STSS_MAG_W'(STSS_HYST_RPM)),
    .BELOW(1'b0)
  ) u_at_speed (
    .clock(clock),
    .reset_n(reset_n),
    .mag(spd_mag),
    .thr(at_thr_x),
    .flag_r(at_flag)
  );

  // the alternate pin carries the same zero speed state
  assign zero_speed_out = zs_flag;
  assign alt_limit_status_out = zs_flag;
  assign speed_match_out = match_flag;
  assign at_speed_out = at_flag;

  // ========================================================================
  // main power sequence
  logic loss_det;
  logic sel_void;
  stss_state_t state_r;
  stss_state_t state_nxt;
  logic uv_error_r;

  stss_ploss_det #(
    .CYC_PER_MS(CYC_PER_MS)
  ) u_ploss (
    .clock(clock),
    .reset_n(reset_n),
    .power_ok(main_power_ok),
    .detect_ms(power_off_detect_time),
    .detected_r(loss_det)
  );

  // with the detect time at its void value only bus voltage trips
  assign sel_void = power_off_detect_time == STSS_DETECT_INVALID_MS;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      STSS_ST_OFF: begin
        if (servo_on_req && main_power_ok && !bus_volt_low) begin
          state_nxt = STSS_ST_ON;
        end
      end
      STSS_ST_ON: begin
        if (bus_volt_low) begin
          state_nxt = STSS_ST_TRIP;
        end else if (loss_det && !sel_void) begin
          state_nxt = trip_sel_r[0] ? STSS_ST_TRIP
                                    : STSS_ST_LOSS;
        end else if (!servo_on_req) begin
          state_nxt = STSS_ST_OFF;
        end
      end
      STSS_ST_LOSS: begin
        if (main_power_ok) begin
          state_nxt = servo_on_req ? STSS_ST_ON : STSS_ST_OFF;
        end
      end
      STSS_ST_TRIP: begin
        if (alarm_clear && main_power_ok && !bus_volt_low) begin
          state_nxt = STSS_ST_OFF;
        end
      end
      default: state_nxt = STSS_ST_OFF;
    endcase
  end

  // state and its decoded outputs move together
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= STSS_ST_OFF;
      servo_active_r <= 1'b0;
      uv_error_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      servo_active_r <= state_nxt == STSS_ST_ON;
      uv_error_r <= state_nxt == STSS_ST_TRIP;
    end
  end

  assign servo_active = servo_active_r;
  assign undervoltage_error = uv_error_r;

  // ========================================================================
  // checks
  a_torque_clamp: assert property (@(posedge clock) disable iff (!reset_n)
    1'b1 |=> (torque_r <= $signed({2'b00, $past(lim_eff)}))
      && (torque_r >= -$signed({2'b00, $past(lim_eff)})))
    else $error("torque beyond limit");

  a_polarity_ccw: assert property (@(posedge clock) disable iff (!reset_n)
    (servo_active_r && polarity_r[0] == 1'b0 && analog_cmd_input_a > 0 &&
     lim_eff != 16'h0000) |=> torque_r > 0)
    else $error("polarity 0 wrong sign");

  a_polarity_cw: assert property (@(posedge clock) disable iff (!reset_n)
    (servo_active_r && polarity_r[0] == 1'b1 && analog_cmd_input_a > 0 &&
     lim_eff != 16'h0000) |=> torque_r < 0)
    else $error("polarity 1 wrong sign");

  a_limit_reject: assert property (@(posedge clock) disable iff (!reset_n)
    (param_wr_en && param_addr == STSS_OFS_FIRST_LIMIT &&
     param_wr_data > sys_max_torque)
      |=> $stable(first_limit_r) && wr_reject_r)
    else $error("limit above max taken");

  a_zero_speed_on: assert property (@(posedge clock) disable iff (!reset_n)
    (reset_n && spd_mag < zs_thr_x) |=> zs_flag)
    else $error("zero speed not set");

  a_zero_speed_off: assert property (@(posedge clock) disable iff (!reset_n)
    ({1'b0, spd_mag} >= {1'b0, zs_thr_x} + 18'(STSS_HYST_RPM))
      |=> !zs_flag)
    else $error("zero speed band wrong");

  a_speed_match: assert property (@(posedge clock) disable iff (!reset_n)
    reset_n |=> match_flag == ($past(diff_mag) < $past(zs_thr_x)))
    else $error("speed match wrong");

  a_at_speed_on: assert property (@(posedge clock) disable iff (!reset_n)
    (reset_n && spd_mag > at_thr_x) |=> at_flag)
    else $error("at speed not set");

  a_at_speed_band: assert property (@(posedge clock) disable iff (!reset_n)
    (at_flag && spd_mag < at_thr_x && {1'b0, spd_mag} + 18'(STSS_HYST_RPM)
     > {1'b0, at_thr_x}) |=> at_flag)
    else $error("at speed left band early");

  a_trip_sel_one: assert property (@(posedge clock) disable iff (!reset_n)
    (state_r == STSS_ST_ON && loss_det && !sel_void && trip_sel_r[0])
      |=> uv_error_r && !servo_active_r)
    else $error("no trip on loss");

  a_trip_sel_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (state_r == STSS_ST_ON && loss_det && !sel_void && !trip_sel_r[0] &&
     !bus_volt_low) |=> !uv_error_r && !servo_active_r)
    else $error("loss did not drop servo");

  a_sel_void: assert property (@(posedge clock) disable iff (!reset_n)
    (state_r == STSS_ST_ON && sel_void && !bus_volt_low && servo_on_req)
      |=> servo_active_r)
    else $error("void select acted");

  a_bus_low_trip: assert property (@(posedge clock) disable iff (!reset_n)
    (state_r == STSS_ST_ON && bus_volt_low) |=> uv_error_r [*1] ##0
      state_r == STSS_ST_TRIP)
    else $error("bus low no trip");

endmodule // stss_core
`default_nettype wire

// [inc/stss_pkg.sv]
// ==========================================================================
// shared constants for the torque and speed status block
package stss_pkg;

  // ========================================================================
  // widths
  localparam int STSS_DATA_W = 16;
  localparam int STSS_ADDR_W = 8;
  localparam int STSS_MAG_W = 17; // speed magnitude, also of a difference
  localparam int STSS_TQ_W = 17; // conditioned torque, signed

  // ========================================================================
  // parameter register offsets
  localparam logic [7:0] STSS_OFS_POLARITY = 8'h5d;
  localparam logic [7:0] STSS_OFS_FIRST_LIMIT = 8'h5e;
  localparam logic [7:0] STSS_OFS_ZS_THR = 8'h61;
  localparam logic [7:0] STSS_OFS_AT_THR = 8'h62;
  localparam logic [7:0] STSS_OFS_TRIP_SEL = 8'h65;

  // ========================================================================
  // reset values and setting ranges
  localparam logic [15:0] STSS_RST_POLARITY = 16'h0000;
  localparam logic [15:0] STSS_RST_FIRST_LIMIT = 16'h01f4;
  localparam logic [15:0] STSS_RST_THR = 16'h0032;
  localparam logic [15:0] STSS_RST_TRIP_SEL = 16'h0001;
  localparam logic [15:0] STSS_FLAG_MAX = 16'h0001;
  localparam logic [15:0] STSS_LIMIT_MAX = 16'h01f4;
  localparam logic [15:0] STSS_THR_MIN = 16'h000a;
  localparam logic [15:0] STSS_THR_MAX = 16'h4e20;
  localparam logic [15:0] STSS_HYST_RPM = 16'h000a;
  localparam logic [15:0] STSS_DETECT_INVALID_MS = 16'h03e8;

  // ========================================================================
  // timing
  localparam int STSS_CLK_PERIOD_NS = 25;
  localparam int STSS_MS_NS = 1000000;
  localparam int STSS_CYC_PER_MS =
    (STSS_MS_NS + STSS_CLK_PERIOD_NS - 1) / STSS_CLK_PERIOD_NS;

  // ========================================================================
  // servo sequence states, one-hot
  typedef enum logic [3:0] {
    STSS_ST_OFF = 4'h1,
    STSS_ST_ON = 4'h2,
    STSS_ST_LOSS = 4'h4,
    STSS_ST_TRIP = 4'h8
  } stss_state_t;

endpackage

// [rtl/stss_hyst_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// magnitude against threshold with a hysteresis band
module stss_hyst_cmp #(
  parameter int W = 17,
  parameter logic [W-1:0] HYST = '0,
  parameter bit BELOW = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // compare inputs
  input wire logic [W-1:0] mag,
  input wire logic [W-1:0] thr,
  // registered flag
  output logic flag_r
);

  logic [W:0] mag_x;
  logic [W:0] thr_x;
  logic set_c;
  logic clr_c;

  // one extra bit keeps the band sums from wrapping
  always_comb begin
    mag_x = {1'b0, mag};
    thr_x = {1'b0, thr};
    if (BELOW) begin
      set_c = mag_x < thr_x;
      clr_c = mag_x >= thr_x + {1'b0, HYST};
    end else begin
      set_c = mag_x > thr_x;
      clr_c = mag_x + {1'b0, HYST} <= thr_x;
    end
  end

  // inside the band the flag holds, so it cannot chatter
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flag_r <= 1'b0;
    end else if (set_c) begin
      flag_r <= 1'b1;
    end else if (clr_c) begin
      flag_r <= 1'b0;
    end
  end

endmodule // stss_hyst_cmp
`default_nettype wire

// [rtl/stss_ploss_det.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// main power loss timer, counts whole milliseconds of shutoff
module stss_ploss_det #(
  parameter int CYC_PER_MS = 40000
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // power state and detect time in ms
  input wire logic power_ok,
  input wire logic [15:0] detect_ms,
  // loss detected, level
  output logic detected_r
);

  localparam int PW = $clog2(CYC_PER_MS + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

  logic [PW-1:0] pre_r;
  logic [15:0] ms_r;

  // millisecond prescaler and saturating ms count while power is off
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pre_r <= '0;
      ms_r <= '0;
    end else if (power_ok) begin
      pre_r <= '0;
      ms_r <= '0;
    end else if (pre_r == PRE_LAST) begin
      pre_r <= '0;
      if (ms_r != 16'hffff) begin
        ms_r <= ms_r + 16'h0001;
      end
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  // a short dip that ends before the detect time is never reported
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      detected_r <= 1'b0;
    end else begin
      detected_r <= !power_ok && (ms_r >= detect_ms);
    end
  end

endmodule // stss_ploss_det
`default_nettype wire

// [tb/stss_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host controller model: command levels and feedback toward the drive
module stss_host_model (
  // clock
  input wire logic clock,
  // command and feedback levels
  output var logic signed [15:0] analog_cmd_input_a,
  output var logic signed [15:0] speed_cmd,
  output var logic signed [15:0] motor_speed,
  // servo and power levels
  output var logic servo_on_req,
  output var logic alarm_clear,
  output var logic main_power_ok,
  output var logic bus_volt_low
);
  // quiet levels at time zero: power present, servo not requested
  initial begin
    analog_cmd_input_a = 16'sh0000;
    speed_cmd = 16'sh0000;
    motor_speed = 16'sh0000;
    servo_on_req = 1'b0;
    alarm_clear = 1'b0;
    main_power_ok = 1'b1;
    bus_volt_low = 1'b0;
  end

  // new torque, speed command and speed, launched on an edge
  task automatic set_motion(input logic signed [15:0] tq, sc, ms);
    @(posedge clock);
    analog_cmd_input_a <= tq;
    speed_cmd <= sc;
    motor_speed <= ms;
  endtask

  // levels are held until changed, like the real host outputs
  task automatic set_ctl(input logic on, clr, pwr, low);
    @(posedge clock);
    servo_on_req <= on;
    alarm_clear <= clr;
    main_power_ok <= pwr;
    bus_volt_low <= low;
  endtask
endmodule // stss_host_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench for the torque and speed status block
module tb_top;
  import stss_pkg::*;

  // ========================================================================
  // signals
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic wr_rej;
  logic [15:0] sys_max = 16'h01f4;
  logic [15:0] det_ms = 16'h0002; // 2 ms of 4 cycles each
  logic signed [15:0] tq_cmd, spd_cmd, spd;
  logic on_req, clr, pwr_ok, bus_low;
  logic signed [16:0] torque;
  logic zs, alt, match, at, active, uv;
  int err_total = 0;
  int n_checks = 0;
  logic [7:0] offs [5] = '{8'h5d, 8'h5e, 8'h61, 8'h62, 8'h65};
  logic [15:0] rstv [5] = '{16'h0000, 16'h01f4, 16'h0032, 16'h0032,
    16'h0001};
  logic [7:0] bad_a [7] = '{8'h5d, 8'h5e, 8'h61, 8'h61, 8'h62, 8'h65,
    8'h70};
  logic [15:0] bad_d [7] = '{16'h0002, 16'h01f5, 16'h0009, 16'h4e21,
    16'h0009, 16'h0002, 16'h0001};
  logic pol_t [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic signed [15:0] cmd_t [4] = '{16'sd200, 16'sd200, -16'sd200,
    -16'sd50};
  logic signed [16:0] exp_t [4] = '{17'sd150, -17'sd150, 17'sd150,
    -17'sd50};

  // clock, 25 ns period
  always #12.5 clock = ~clock;

  // ========================================================================
  // instances; short millisecond keeps loss timing cheap
  stss_core #(.CYC_PER_MS(4)) i_dut (
    .clock(clock), .reset_n(reset_n),
    .param_wr_en(wr_en), .param_rd_en(rd_en), .param_addr(addr),
    .param_wr_data(wdata), .param_rd_data(rdata),
    .param_wr_reject(wr_rej),
    .sys_max_torque(sys_max), .power_off_detect_time(det_ms),
    .analog_cmd_input_a(tq_cmd), .speed_cmd(spd_cmd),
    .motor_speed(spd), .servo_on_req(on_req), .alarm_clear(clr),
    .main_power_ok(pwr_ok), .bus_volt_low(bus_low),
    .torque_out(torque), .zero_speed_out(zs),
    .alt_limit_status_out(alt), .speed_match_out(match),
    .at_speed_out(at), .servo_active(active), .undervoltage_error(uv)
  );
  stss_host_model i_host (
    .clock(clock), .analog_cmd_input_a(tq_cmd), .speed_cmd(spd_cmd),
    .motor_speed(spd), .servo_on_req(on_req), .alarm_clear(clr),
    .main_power_ok(pwr_ok), .bus_volt_low(bus_low)
  );

  // ========================================================================
  // tasks
  task automatic final_report();
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [16:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one edge passes, then its register updates are allowed to land
  task automatic settle();
    @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic rej);
    @(posedge clock);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
    chk(17'(wr_rej), 17'(rej), "write reject");
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    chk(17'(rdata), 17'(exp), "read data");
  endtask

  // bounded wait on servo_active (sel 1) or undervoltage_error (sel 0)
  task automatic wait_lvl(input logic sel, input logic lvl, input int lim);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      settle();
      hit = ((sel ? active : uv) === lvl);
    end
    if (!hit) begin
      err_total++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask

  // ========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    chk(17'({active, uv}), 17'h0, "outputs in reset");
    reset_n <= 1'b1;
    // refused writes keep the reset values; unmapped reads give 0
    for (int i = 0; i < 7; i++) wr(bad_a[i], bad_d[i], 1'b1);
    for (int i = 0; i < 5; i++) rd(offs[i], rstv[i]);
    rd(8'h70, 16'h0000);
    wr(8'h61, 16'h000a, 1'b0);
    wr(8'h61, 16'h4e20, 1'b0);
    wr(8'h61, 16'h0032, 1'b0);
    @(posedge clock);
    sys_max <= 16'h012c;
    wr(8'h5e, 16'h0190, 1'b1);
    // speed flags with threshold 50 and 10 rpm band
    i_host.set_motion(16'sd0, 16'sd0, -16'sd40);
    settle();
    chk(17'({zs, alt, at}), 17'h6, "zero speed neg");
    i_host.set_motion(16'sd0, 16'sd0, -16'sd55);
    settle();
    chk(17'({zs, at}), 17'h3, "inside band neg");
    i_host.set_motion(16'sd0, 16'sd0, 16'sd60);
    settle();
    chk(17'({zs, alt, at}), 17'h1, "band edge pos");
    i_host.set_motion(16'sd0, 16'sd0, 16'sd45);
    settle();
    chk(17'({zs, at}), 17'h3, "at speed band");
    i_host.set_motion(16'sd0, 16'sd0, 16'sd40);
    settle();
    chk(17'({zs, at}), 17'h2, "at speed clears");
    i_host.set_motion(16'sd0, 16'sd100, 16'sd60);
    settle();
    chk(17'(match), 17'h1, "match close");
    i_host.set_motion(16'sd0, -16'sd100, -16'sd40);
    settle();
    chk(17'(match), 17'h0, "match far");
    i_host.set_motion(16'sd0, 16'sd0, 16'sd95);
    settle();
    chk(17'(zs), 17'h0, "zero speed off");
    wr(8'h61, 16'h00c8, 1'b0);
    settle();
    chk(17'(zs), 17'h1, "new threshold used");
    // torque path: zero while servo off, then polarity and clamp
    wr(8'h5e, 16'h0096, 1'b0);
    i_host.set_motion(16'sd200, 16'sd0, 16'sd0);
    settle();
    chk(torque, 17'h0, "torque servo off");
    i_host.set_ctl(1'b1, 1'b0, 1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1, 10);
    for (int i = 0; i < 4; i++) begin
      wr(8'h5d, {15'h0, pol_t[i]}, 1'b0);
      i_host.set_motion(cmd_t[i], 16'sd0, 16'sd0);
      settle();
      chk(torque, exp_t[i], "torque clamp");
    end
    @(posedge clock);
    sys_max <= 16'h0064;
    i_host.set_motion(16'sd200, 16'sd0, 16'sd0);
    settle();
    chk(torque, 17'sd100, "system maximum");
    // trip select 1: loss lasts the detect time, then trips
    i_host.set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (4) settle();
    chk(17'({active, uv}), 17'h2, "loss too short");
    wait_lvl(1'b0, 1'b1, 40);
    settle();
    chk({active, torque[15:0]}, 17'h0, "trip drops servo");
    i_host.set_ctl(1'b1, 1'b1, 1'b1, 1'b0);
    i_host.set_ctl(1'b1, 1'b0, 1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1, 10);
    chk(17'(uv), 17'h0, "alarm cleared");
    // trip select 0: servo drops and resumes, no error
    wr(8'h65, 16'h0000, 1'b0);
    i_host.set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    wait_lvl(1'b1, 1'b0, 40);
    chk(17'(uv), 17'h0, "no trip select 0");
    i_host.set_ctl(1'b1, 1'b0, 1'b1, 1'b0);
    wait_lvl(1'b1, 1'b1, 10);
    // detect time 1000: loss ignored, bus low still trips
    @(posedge clock);
    det_ms <= STSS_DETECT_INVALID_MS;
    i_host.set_ctl(1'b1, 1'b0, 1'b0, 1'b0);
    repeat (60) settle();
    chk(17'({active, uv}), 17'h2, "select ignored");
    i_host.set_ctl(1'b1, 1'b0, 1'b0, 1'b1);
    wait_lvl(1'b0, 1'b1, 10);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
